// ===== core/tmr_ff_pkg.sv
// Constants, register map and field layout of the timer flip-flop and event flag block
// How it works
// - With the capture-one toggle enable set, each load of capture register one inverts the output flip-flop.
// - With the capture-zero toggle enable set, each load of capture register zero inverts the output flip-flop.
// - With the match-one toggle enable set, each match with compare register one inverts the output flip-flop.
// - With the match-zero toggle enable set, each match with compare register zero inverts the output flip-flop.
// - Writing 00 to the flip-flop command field inverts the output flip-flop once.
// - Writing 01 to the command field sets the output flip-flop and writing 10 clears it.
// - Writing 11 to the command field changes nothing, and the field always reads 11.
// - A counter overflow sets status bit 2.
// - A match with compare register one sets status bit 1.
// - A match with compare register zero sets status bit 0.
// - Status flags are set whatever the mask says.
// - An event reaches the interrupt output only when its mask bit allows it.
// - Reading the status register clears the flags it showed; software clears them only that way.
// - Mask bit 2 gates overflow, bit 1 match one, bit 0 match zero; 1 allows and 0 blocks.
package tmr_ff_pkg;
  // ==========================================
  // Register byte addresses
  localparam logic [7:0] ADDR_FF_CTRL = 8'h00;
  localparam logic [7:0] ADDR_EVT_STATUS = 8'h04;
  localparam logic [7:0] ADDR_EVT_MASK = 8'h08;
  // ==========================================
  // Field positions
  localparam int unsigned BIT_TOG_CAP1 = 5;
  localparam int unsigned BIT_TOG_CAP0 = 4;
  localparam int unsigned BIT_TOG_MATCH1 = 3;
  localparam int unsigned BIT_TOG_MATCH0 = 2;
  localparam int unsigned BIT_OVF = 2;
  localparam int unsigned BIT_MATCH1 = 1;
  localparam int unsigned BIT_MATCH0 = 0;
  // ==========================================
  // Command codes and reset values
  localparam logic [1:0] CMD_INVERT = 2'h0;
  localparam logic [1:0] CMD_SET = 2'h1;
  localparam logic [1:0] CMD_CLEAR = 2'h2;
  localparam logic [1:0] CMD_NONE = 2'h3;
  localparam logic [3:0] RST_TOG_EN = 4'h0;
  localparam logic [2:0] RST_FLAGS = 3'h0;
  localparam logic [2:0] RST_MASK = 3'h0;
  localparam logic RST_FF = 1'b0;
  localparam logic [1:0] FF_CTRL_HIGH_BITS = 2'h3;
endpackage

// ===== core/evt_flag.sv
// One sticky event flag, set by hardware and cleared by a status read
`timescale 1ns/1ps
`default_nettype none
module evt_flag
  import tmr_ff_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // Event and clear
  input wire logic i_set,
  input wire logic i_clr,
  // Flag
  output logic o_flag
);
  // Set beats clear so an event in the read cycle stays visible
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_flag <= 1'b0;
    end else if (i_set) begin
      o_flag <= 1'b1;
    end else if (i_clr) begin
      o_flag <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== core/tmr_ff_ctrl.sv
// Timer output flip-flop control, event flags and interrupt mask behind APB
`timescale 1ns/1ps
`default_nettype none
module tmr_ff_ctrl
  import tmr_ff_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Timer event strobes, one cycle each, same clock
  input wire logic i_match_zero,
  input wire logic i_match_one,
  input wire logic i_capture_zero,
  input wire logic i_capture_one,
  input wire logic i_overflow,
  // Outputs
  output logic o_timer_output_flipflop,
  output logic o_irq
);
  // ==========================================
  // Bus decode
  logic setup_cyc;
  logic wr_ctrl;
  logic wr_mask;
  logic rd_status;
  logic mapped;
  logic [3:0] toggle_en_reg;
  logic [2:0] mask_reg;
  logic [2:0] flags;
  logic [2:0] flag_set;
  logic hw_toggle;
  logic [31:0] rdata_next;

  // Answer in the setup cycle's next edge: pready is always high in access
  assign setup_cyc = i_psel && !i_penable;
  assign mapped = (i_paddr == ADDR_FF_CTRL) || (i_paddr == ADDR_EVT_STATUS) ||
    (i_paddr == ADDR_EVT_MASK);
  // Writes only take effect with byte lane 0 enabled; all fields live there
  assign wr_ctrl = i_psel && i_penable && i_pwrite && i_pstrb[0] && (i_paddr == ADDR_FF_CTRL);
  assign wr_mask = i_psel && i_penable && i_pwrite && i_pstrb[0] && (i_paddr == ADDR_EVT_MASK);
  assign rd_status = i_psel && i_penable && !i_pwrite && (i_paddr == ADDR_EVT_STATUS);

  // Ready comes from a flop set in setup and dropped after access
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= setup_cyc;
      o_pslverr <= setup_cyc && !mapped;
    end
  end

  // Read data is built in setup so it sits in a flop during access
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (i_paddr == ADDR_FF_CTRL) begin
      rdata_next[7:6] = FF_CTRL_HIGH_BITS;
      rdata_next[5:2] = toggle_en_reg;
      rdata_next[1:0] = CMD_NONE;
    end else if (i_paddr == ADDR_EVT_STATUS) begin
      rdata_next[2:0] = flags;
    end else if (i_paddr == ADDR_EVT_MASK) begin
      rdata_next[2:0] = mask_reg;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_prdata <= 32'h0000_0000;
    end else if (setup_cyc && !i_pwrite) begin
      o_prdata <= rdata_next;
    end
  end

  // ==========================================
  // Control and mask registers
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      toggle_en_reg <= RST_TOG_EN;
    end else if (wr_ctrl) begin
      toggle_en_reg <= i_pwdata[BIT_TOG_CAP1:BIT_TOG_MATCH0];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mask_reg <= RST_MASK;
    end else if (wr_mask) begin
      mask_reg <= i_pwdata[2:0];
    end
  end

  // ==========================================
  // Output flip-flop
  // Hardware triggers merge into one toggle; two in one cycle still toggle once
  assign hw_toggle =
    (toggle_en_reg[BIT_TOG_CAP1 - 2] && i_capture_one) ||
    (toggle_en_reg[BIT_TOG_CAP0 - 2] && i_capture_zero) ||
    (toggle_en_reg[BIT_TOG_MATCH1 - 2] && i_match_one) ||
    (toggle_en_reg[BIT_TOG_MATCH0 - 2] && i_match_zero);

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_timer_output_flipflop <= RST_FF;
    end else if (wr_ctrl && i_pwdata[1:0] != CMD_NONE) begin
      // Software command overrides any hardware toggle in this cycle
      unique case (i_pwdata[1:0])
        CMD_INVERT: o_timer_output_flipflop <= !o_timer_output_flipflop;
        CMD_SET: o_timer_output_flipflop <= 1'b1;
        CMD_CLEAR: o_timer_output_flipflop <= 1'b0;
        default: o_timer_output_flipflop <= o_timer_output_flipflop;
      endcase
    end else if (hw_toggle) begin
      o_timer_output_flipflop <= !o_timer_output_flipflop;
    end
  end

  // ==========================================
  // Event flags, cleared by reading the status register
  assign flag_set[BIT_OVF] = i_overflow;
  assign flag_set[BIT_MATCH1] = i_match_one;
  assign flag_set[BIT_MATCH0] = i_match_zero;

  // A read clears only the flags it returned, so an event landing on the setup edge is not lost
  for (genvar g = 0; g < 3; g++) begin : g_flag
    evt_flag u_flag (
      .i_clk_sys(i_clk_sys),
      .i_rst_b(i_rst_b),
      .i_set(flag_set[g]),
      .i_clr(rd_status && o_prdata[g]),
      .o_flag(flags[g])
    );
  end

  // Interrupt level follows the registered unmasked flags
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(flags & mask_reg);
    end
  end

  // ==========================================
  // Checks: bus handshake
  // Ready answers every setup on the next edge
  a_ready_after_setup: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    setup_cyc |=> o_pready)
    else $error("ready missing after setup");
  // Ready stands for the access cycle only
  a_ready_one_cycle: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    o_pready && !setup_cyc |=> !o_pready)
    else $error("ready stood too long");
  // An error never comes without ready
  a_err_with_ready: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    o_pslverr |-> o_pready)
    else $error("error without ready");
  // Unmapped addresses answer with an error and zero data, mapped ones without error
  a_err_unmapped: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    setup_cyc && !mapped |=> o_pslverr)
    else $error("unmapped access without error");
  a_no_err_mapped: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    setup_cyc && mapped |=> !o_pslverr)
    else $error("mapped access flagged as error");
  a_rd_unmapped_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    setup_cyc && !i_pwrite && !mapped |=> o_prdata == 32'h0000_0000)
    else $error("unmapped read returned data");
  // Read data holds between reads, so a slow master still sees it
  a_rdata_holds: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    !(setup_cyc && !i_pwrite) |=> $stable(o_prdata))
    else $error("read data changed outside a read");

  // ==========================================
  // Checks: register contents
  // Status read returns the flags as they stood at setup
  a_rd_status_value: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    setup_cyc && !i_pwrite && i_paddr == ADDR_EVT_STATUS |=> o_prdata == {29'h0, $past(flags)})
    else $error("status read data wrong");
  // Mask reads back as written
  a_rd_mask_value: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    setup_cyc && !i_pwrite && i_paddr == ADDR_EVT_MASK |=> o_prdata == {29'h0, $past(mask_reg)})
    else $error("mask read data wrong");
  // Control reads ones on top, the enables, and 11 in the command field
  a_rd_ctrl_enables: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    setup_cyc && !i_pwrite && i_paddr == ADDR_FF_CTRL |=>
    o_prdata == {24'h0, FF_CTRL_HIGH_BITS, $past(toggle_en_reg), CMD_NONE})
    else $error("control read data wrong");
  a_ctrl_reads_11: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    setup_cyc && !i_pwrite && i_paddr == ADDR_FF_CTRL |=> o_prdata[1:0] == CMD_NONE && o_prdata[7:6] == 2'h3)
    else $error("command field did not read 11");
  // Writes land on the access edge and nothing else moves the registers
  a_mask_write: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    wr_mask |=> mask_reg == $past(i_pwdata[2:0]))
    else $error("mask write lost");
  a_mask_holds: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    !wr_mask |=> $stable(mask_reg))
    else $error("mask changed without write");
  a_enable_write: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    wr_ctrl |=> toggle_en_reg == $past(i_pwdata[5:2]))
    else $error("toggle enable write lost");
  a_enable_holds: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    !wr_ctrl |=> $stable(toggle_en_reg))
    else $error("toggle enables changed without write");
  // A write without byte lane 0 is dropped
  a_strobe_ignored: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_psel && i_penable && i_pwrite && !i_pstrb[0] |=> $stable(mask_reg) && $stable(toggle_en_reg))
    else $error("write without lane 0 took effect");

  // ==========================================
  // Checks: output flip-flop
  // Software commands
  a_cmd_set_wins: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    wr_ctrl && i_pwdata[1:0] == CMD_SET |=> o_timer_output_flipflop)
    else $error("set command did not set output");
  a_cmd_clr_wins: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    wr_ctrl && i_pwdata[1:0] == CMD_CLEAR |=> !o_timer_output_flipflop)
    else $error("clear command did not clear output");
  a_cmd_invert: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    wr_ctrl && i_pwdata[1:0] == CMD_INVERT |=> o_timer_output_flipflop != $past(o_timer_output_flipflop))
    else $error("invert command did not toggle");
  // Invert with a hardware toggle on the same edge still flips only once
  a_cmd_beats_hw: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    wr_ctrl && i_pwdata[1:0] == CMD_INVERT && hw_toggle |=>
    o_timer_output_flipflop != $past(o_timer_output_flipflop))
    else $error("command and hardware toggle both applied");
  // Command 11 leaves the output to the hardware triggers
  a_cmd_none_keeps: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    wr_ctrl && i_pwdata[1:0] == CMD_NONE && !hw_toggle |=> $stable(o_timer_output_flipflop))
    else $error("command 11 changed output");
  a_cmd_none_hw: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    wr_ctrl && i_pwdata[1:0] == CMD_NONE && hw_toggle |=>
    o_timer_output_flipflop != $past(o_timer_output_flipflop))
    else $error("command 11 blocked hardware toggle");
  // Hardware triggers, one per source
  a_hw_toggle: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    !wr_ctrl && toggle_en_reg[3] && i_capture_one |=> o_timer_output_flipflop != $past(o_timer_output_flipflop))
    else $error("capture one toggle missed");
  a_cap0_toggle: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    !wr_ctrl && toggle_en_reg[2] && i_capture_zero |=> o_timer_output_flipflop != $past(o_timer_output_flipflop))
    else $error("capture zero toggle missed");
  a_match1_toggle: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    !wr_ctrl && toggle_en_reg[1] && i_match_one |=> o_timer_output_flipflop != $past(o_timer_output_flipflop))
    else $error("match one toggle missed");
  a_match0_toggle: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    !wr_ctrl && toggle_en_reg[0] && i_match_zero |=> o_timer_output_flipflop != $past(o_timer_output_flipflop))
    else $error("match zero toggle missed");
  // Disabled or absent triggers leave the output alone
  a_no_toggle_idle: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    !wr_ctrl && !hw_toggle |=> $stable(o_timer_output_flipflop))
    else $error("output changed without cause");
  a_no_enabled_event: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    !wr_ctrl && (toggle_en_reg & {i_capture_one, i_capture_zero, i_match_one, i_match_zero}) == 4'h0 |=>
    $stable(o_timer_output_flipflop))
    else $error("disabled trigger toggled output");

  // ==========================================
  // Checks: event flags
  // Overflow and both matches each set their own flag; captures set none
  a_ovf_flag_set: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_overflow |=> flags[2])
    else $error("overflow flag not set");
  a_match_flags: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_match_one && i_match_zero |=> flags[1] && flags[0])
    else $error("match flags not set");
  a_match_one_flag: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_match_one |=> flags[1])
    else $error("match one flag not set");
  a_match_zero_flag: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_match_zero |=> flags[0])
    else $error("match zero flag not set");
  // A blocked request still records its flag
  a_flag_despite_mask: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_overflow && !mask_reg[2] |=> flags[2])
    else $error("masked overflow not recorded");
  // Flags only fall through a status read, and only those it returned
  a_read_clears: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    rd_status && !i_overflow && !i_match_one && !i_match_zero |=> (flags & $past(o_prdata[2:0])) == 3'h0)
    else $error("status read did not clear flags");
  a_flags_sticky: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    !rd_status |=> (flags & $past(flags)) == $past(flags))
    else $error("flag dropped without a read");
  a_flags_no_cause: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    !i_overflow && !i_match_one && !i_match_zero && !rd_status |=> $stable(flags))
    else $error("flags changed without cause");

  // ==========================================
  // Checks: interrupt
  // The level follows last cycle's unmasked flags
  a_irq_gate: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    ##1 o_irq == |($past(flags) & $past(mask_reg)))
    else $error("interrupt does not follow masked flags");
  a_irq_blocked: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    mask_reg == 3'h0 |=> !o_irq)
    else $error("interrupt passed a full mask");
  a_irq_no_flags: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    flags == 3'h0 |=> !o_irq)
    else $error("interrupt without a flag");
  a_irq_overflow: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    flags[2] && mask_reg[2] |=> o_irq)
    else $error("overflow interrupt missing");
  a_irq_match_one: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    flags[1] && mask_reg[1] |=> o_irq)
    else $error("match one interrupt missing");
  a_irq_match_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    flags[0] && mask_reg[0] |=> o_irq)
    else $error("match zero interrupt missing");
endmodule
`default_nettype wire

// ===== sim/tmr_ff_ctrl_tb.sv
// Self-checking bench for the timer flip-flop control and event flag block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module tmr_ff_ctrl_tb;
  import tmr_ff_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst_b = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0] pstrb = 4'h0;
  logic pready, pslverr, ff, irq;
  logic [4:0] ev_bus = 5'h00; // Overflow, capture one, capture zero, match one, match zero
  logic ff_m = 1'b0;
  logic [3:0] en_m = 4'h0;
  logic [2:0] fl_m = 3'h0, mk_m = 3'h0;
  int failures = 0, checked = 0;
  always #12.5 i_clk_sys = ~i_clk_sys;
  tmr_ff_ctrl i_tmr_ff_ctrl (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_match_zero(ev_bus[0]), .i_match_one(ev_bus[1]),
    .i_capture_zero(ev_bus[2]), .i_capture_one(ev_bus[3]), .i_overflow(ev_bus[4]),
    .o_timer_output_flipflop(ff), .o_irq(irq));
  // ==========================================
  // Expected register contents
  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    case (a)
      ADDR_FF_CTRL: exp_rd = {24'h0, FF_CTRL_HIGH_BITS, en_m, CMD_NONE};
      ADDR_EVT_STATUS: exp_rd = {29'h0, fl_m};
      ADDR_EVT_MASK: exp_rd = {29'h0, mk_m};
      default: exp_rd = 32'h0;
    endcase
  endfunction
  // ==========================================
  // APB transfer; events ride along so they land on the access edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] st,
                     input logic [4:0] ev);
    logic [31:0] exp;
    logic err;
    logic cmd_hit;
    exp = exp_rd(a);
    err = !(a == ADDR_FF_CTRL || a == ADDR_EVT_STATUS || a == ADDR_EVT_MASK);
    cmd_hit = wr && st[0] && a == ADDR_FF_CTRL && d[1:0] != CMD_NONE;
    @(posedge i_clk_sys);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d; pstrb <= st;
    @(posedge i_clk_sys);
    penable <= 1'b1; ev_bus <= ev;
    // No cycle count assumed: a hung slave is caught by the watchdog
    do @(posedge i_clk_sys); while (pready !== 1'b1);
    `CHK(pslverr, err)
    if (!wr) `CHK(prdata, exp)
    psel <= 1'b0; penable <= 1'b0; ev_bus <= 5'h00;
    // Software command beats any hardware toggle on the same edge
    if (cmd_hit) ff_m = d[1:0] == CMD_INVERT ? ~ff_m : d[1:0] == CMD_SET;
    else ff_m ^= |(en_m & ev[3:0]);
    if (!wr && a == ADDR_EVT_STATUS) fl_m = 3'h0;
    fl_m |= {ev[4], ev[1], ev[0]};
    if (wr && st[0] && a == ADDR_FF_CTRL) en_m = d[5:2];
    if (wr && st[0] && a == ADDR_EVT_MASK) mk_m = d[2:0];
    #1 `CHK(ff, ff_m)
  endtask
  task automatic pulse(input logic [4:0] ev);
    @(posedge i_clk_sys);
    ev_bus <= ev;
    @(posedge i_clk_sys);
    ev_bus <= 5'h00;
    ff_m ^= |(en_m & ev[3:0]);
    fl_m |= {ev[4], ev[1], ev[0]};
    #1 `CHK(ff, ff_m)
  endtask
  // Interrupt follows the gated flags one cycle later
  task automatic chk_irq();
    @(posedge i_clk_sys);
    #1 `CHK(irq, |(fl_m & mk_m))
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ==========================================
  // Watchdog sized well above the whole sequence
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    failures++;
    end_sim();
  end
  logic [1:0] cmds [5] = '{CMD_SET, CMD_INVERT, CMD_CLEAR, CMD_INVERT, CMD_NONE};
  initial begin
    void'($urandom(67216));
    repeat (12) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    #1 `CHK(ff, 1'b0)
    for (int i = 0; i < 3; i++) apb(1'b0, 8'(4 * i), 32'h0, 4'h0, 5'h00);
    foreach (cmds[i]) apb(1'b1, ADDR_FF_CTRL, {30'h0, cmds[i]}, 4'hF, 5'h00);
    apb(1'b0, ADDR_FF_CTRL, 32'h0, 4'h0, 5'h00);
    // Each source alone, every toggle enabled and all events unmasked
    apb(1'b1, ADDR_EVT_MASK, 32'h7, 4'hF, 5'h00);
    apb(1'b1, ADDR_FF_CTRL, 32'h3F, 4'hF, 5'h00);
    for (int k = 0; k < 5; k++) begin pulse(5'(1 << k)); chk_irq(); end
    apb(1'b0, ADDR_EVT_STATUS, 32'h0, 4'h0, 5'h00);
    chk_irq();
    // Random enables, masks and event mixes
    for (int i = 0; i < 60; i++) begin
      apb(1'b1, ADDR_EVT_MASK, $urandom, 4'hF, 5'h00);
      apb(1'b1, ADDR_FF_CTRL, {30'($urandom), 2'b11}, 4'hF, 5'h00);
      pulse(5'($urandom));
      chk_irq();
      if (i % 4 == 3) apb(1'b0, ADDR_EVT_STATUS, 32'h0, 4'h0, 5'h00);
    end
    apb(1'b1, ADDR_FF_CTRL, 32'h3D, 4'hF, 5'h1F);
    apb(1'b1, ADDR_FF_CTRL, 32'h3C, 4'hF, 5'h0F);
    apb(1'b1, ADDR_FF_CTRL, 32'h3F, 4'hF, 5'h01);
    apb(1'b0, ADDR_EVT_STATUS, 32'h0, 4'h0, 5'h10);
    apb(1'b0, ADDR_EVT_STATUS, 32'h0, 4'h0, 5'h00);
    // Refused accesses leave everything untouched
    apb(1'b0, 8'h0C, 32'h0, 4'h0, 5'h00);
    apb(1'b1, 8'h0C, 32'hFF, 4'hF, 5'h00);
    apb(1'b1, ADDR_EVT_MASK, 32'h0, 4'h0, 5'h00);
    apb(1'b0, ADDR_EVT_MASK, 32'h0, 4'h0, 5'h00);
    end_sim();
  end
endmodule
`default_nettype wire
